// File: dv/host_model.sv
// Host model: drives the decoded register port the way the serial engine would.
// Assumes ref_clk is shared with the register bank; the bench calls its tasks.
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic ref_clk,
  // Register port
  output logic [11:0] reg_addr,
  output logic [15:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [15:0] reg_rdata
);
  initial begin
    reg_addr = 12'h000;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // setup register writes and reads
  task wr(input logic [11:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  task rd(input logic [11:0] a, output logic [15:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1 d = reg_rdata;
  endtask : rd
endmodule : host_model

// File: dv/touch_setup_regs_tb_top.sv
// Self-checking bench of the touch setup register bank.
// Assumes the register bank and host model on one 100 MHz clock.
`timescale 1ns/1ps
`include "touch_setup_params.svh"
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin failures++; \
  $display("BAD %s exp %h got %h", nm, ex, gt); end end
module touch_setup_regs_tb_top;
  typedef struct {logic wr; logic [11:0] addr; logic [15:0] wdata; logic [15:0] exp;} row_t;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [11:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, cmp_high = 1'b0, cmp_low = 1'b0;
  logic [19:0] touch_event = 20'h00000;
  logic sense_enable, ambient_cal_en, noise_rejection_on, soft_reset_pulse, irq_out_pin;
  logic [11:0] noise_rejection_settings;
  logic [4:0] cal_chan;
  logic [7:0] cal_setting;
  int failures = 0, n_checks = 0, cycles = 0, i;
  row_t rows[14] = '{'{0, 12'h043, 16'h0, 16'h0000}, '{0, 12'h044, 16'h0, 16'h0300},
    '{0, 12'h04E, 16'h0, 16'h0002}, '{0, 12'h077, 16'h0, 16'h0000},
    '{0, 12'h040, 16'h0, 16'h0000}, '{0, 12'h008, 16'h0, 16'h0000},
    '{1, 12'h100, 16'hFFFF, 16'h0000}, '{1, 12'h077, 16'h8ABC, 16'h8ABC},
    '{1, 12'h04E, 16'h6005, 16'h2007}, '{1, 12'h043, 16'h03FF, 16'h03FF},
    '{1, 12'h044, 16'h0004, 16'h0004}, '{1, 12'h045, 16'hFFFF, 16'h0000},
    '{1, 12'h046, 16'hFFFF, 16'h0000}, '{1, 12'h040, 16'h8000, 16'h8000}};

  always #5 ref_clk = ~ref_clk;

  host_model i_host (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  touch_setup_regs i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .touch_event(touch_event), .cmp_high(cmp_high), .cmp_low(cmp_low),
    .sense_enable(sense_enable), .ambient_cal_en(ambient_cal_en),
    .noise_rejection_on(noise_rejection_on),
    .noise_rejection_settings(noise_rejection_settings),
    .soft_reset_pulse(soft_reset_pulse), .cal_chan(cal_chan), .cal_setting(cal_setting),
    .irq_out_pin(irq_out_pin));

  ////////////////////////////////////////////////////////////////////////////
  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  // One event pulse on a channel, then the two cycles until the pin answers
  task touch(input int ch);
    @(posedge ref_clk);
    touch_event <= 20'h00001 << ch;
    @(posedge ref_clk);
    touch_event <= 20'h00000;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask : touch

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    `CHK("irq idle", 1'b1, irq_out_pin)
    for (i = 0; i < 14; i++) begin
      if (rows[i].wr) i_host.wr(rows[i].addr, rows[i].wdata);
      i_host.rd(rows[i].addr, d);
      `CHK("reg row", rows[i].exp, d)
    end
    `CHK("noise on", 1'b1, noise_rejection_on)
    `CHK("noise set", 12'hABC, noise_rejection_settings)
    `CHK("sense", 1'b1, sense_enable)
    $display("register rows done");
    i_host.wr(`OFS_SOFT_RESET, 16'h0000);
    #1 `CHK("sreset pulse", 1'b1, soft_reset_pulse)
    @(posedge ref_clk);
    cmp_low <= 1'b1;
    for (i = 0; i < 300 && cal_setting === 8'h80; i++) @(negedge ref_clk);
    `CHK("step up", 8'h85, cal_setting)
    `CHK("chan0", 5'h00, cal_chan)
    i_host.rd(`OFS_CAL_CTRL, d);
    `CHK("cal busy", 1'b0, d[14])
    @(posedge ref_clk);
    cmp_low <= 1'b0;
    for (i = 0; i < 300 && cal_chan === 5'h00; i++) @(negedge ref_clk);
    `CHK("chan1", 5'h01, cal_chan)
    for (i = 0; i < 30 && d[14] !== 1'b1; i++) begin
      repeat (100) @(posedge ref_clk);
      i_host.rd(`OFS_CAL_CTRL, d);
    end
    `CHK("cal done", 16'h6007, d)
    `CHK("amb off", 1'b0, ambient_cal_en)
    i_host.wr(`OFS_CAL_CTRL, 16'h0004);
    @(negedge ref_clk);
    `CHK("amb on", 1'b1, ambient_cal_en)
    i_host.rd(`OFS_IRQ_EN_LO, d);
    `CHK("cfg kept", 16'h03FF, d)
    $display("calibration done");
    touch(12);
    `CHK("irq ch12", 1'b0, irq_out_pin)
    i_host.rd(`OFS_FLAGS_HI, d);
    `CHK("flag ch12", 16'h0004, d)
    @(posedge ref_clk);
    #1 `CHK("irq clr", 1'b1, irq_out_pin)
    touch(13);
    `CHK("irq ch13", 1'b1, irq_out_pin)
    i_host.rd(`OFS_FLAGS_HI, d);
    `CHK("flag ch13", 16'h0000, d)
    i_host.wr(`OFS_IRQ_CONFIG, 16'h8000);
    touch(5);
    `CHK("irq pol", 1'b1, irq_out_pin)
    i_host.rd(`OFS_FLAGS_LO, d);
    `CHK("flag ch5", 16'h0020, d)
    i_host.wr(`OFS_TOUCH_CTRL, 16'h0000);
    touch(5);
    `CHK("irq sense off", 1'b0, irq_out_pin)
    i_host.rd(`OFS_FLAGS_LO, d);
    `CHK("flag sense off", 16'h0000, d)
    $display("interrupt tests done");
    // Adaptive step: start at 8 going down, then halve on reversal
    @(posedge ref_clk);
    cmp_high <= 1'b1;
    i_host.wr(`OFS_CAL_CTRL, 16'h0000);
    i_host.wr(`OFS_SOFT_RESET, 16'hFFFF);
    for (i = 0; i < 300 && cal_setting === 8'h80; i++) @(negedge ref_clk);
    `CHK("adapt down", 8'h78, cal_setting)
    `CHK("amb restart", 1'b0, ambient_cal_en)
    @(posedge ref_clk);
    cmp_high <= 1'b0;
    cmp_low <= 1'b1;
    for (i = 0; i < 300 && cal_setting === 8'h78; i++) @(negedge ref_clk);
    `CHK("reversal", 8'h80, cal_setting)
    for (i = 0; i < 300 && cal_setting === 8'h80; i++) @(negedge ref_clk);
    `CHK("halved step", 8'h84, cal_setting)
    $display("adaptive step done");
    stop_test();
  end
endmodule : touch_setup_regs_tb_top

// File: rtl/cal_sequencer.sv
// Initial calibration sequencer: sweeps all channels toward a no-touch baseline.
// Assumes a synchronous reset copy, a tick enable and front-end compare flags on ref_clk.
`timescale 1ns/1ps
`include "touch_setup_params.svh"
module cal_sequencer
  import touch_setup_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_sync_b,
  // Control
  input wire logic start,
  input wire logic tick,
  input wire logic [3:0] cal_step_size,
  // Front-end compare for the channel under calibration
  input wire logic cmp_high,
  input wire logic cmp_low,
  // Results
  output logic [4:0] cal_chan,
  output logic [7:0] cal_setting,
  output logic cal_done
);
  cal_state_t state_reg;
  logic [7:0] delta_reg;
  logic [7:0] iter_reg;
  logic last_up_reg;
  logic settled;
  logic reverse;
  logic [8:0] sum_up;
  logic [8:0] sum_dn;

  assign settled = (!cmp_high && !cmp_low) || (iter_reg == `CAL_MAX_ITER);
  assign reverse = (iter_reg != 8'h00) && (last_up_reg != cmp_low);
  assign sum_up = {1'b0, cal_setting} + {1'b0, delta_reg};
  assign sum_dn = {1'b0, cal_setting} - {1'b0, delta_reg};
  assign cal_done = (state_reg == CAL_DONE);

  //////////////////////////////////////////////////////////////////////////////
  // [RULE4] step applied per channel
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      state_reg <= CAL_IDLE;
      cal_chan <= 5'h00;
      cal_setting <= `CAL_SETTING_MID;
      delta_reg <= `CAL_ADAPT_START;
      iter_reg <= 8'h00;
      last_up_reg <= 1'b0;
    end else if (start) begin
      state_reg <= CAL_RUN;
      cal_chan <= 5'h00;
      cal_setting <= `CAL_SETTING_MID;
      // [RULE3] adaptive or fixed step
      delta_reg <= (cal_step_size == 4'h0) ? `CAL_ADAPT_START : {4'h0, cal_step_size};
      iter_reg <= 8'h00;
      last_up_reg <= 1'b0;
    end else if (state_reg == CAL_RUN && tick) begin
      if (settled) begin
        state_reg <= (cal_chan == `LAST_CHANNEL) ? CAL_DONE : CAL_RUN;
        cal_chan <= (cal_chan == `LAST_CHANNEL) ? cal_chan : cal_chan + 5'h01;
        cal_setting <= `CAL_SETTING_MID;
        delta_reg <= (cal_step_size == 4'h0) ? `CAL_ADAPT_START : {4'h0, cal_step_size};
        iter_reg <= 8'h00;
      end else begin
        if (cmp_low) begin
          cal_setting <= sum_up[8] ? 8'hFF : sum_up[7:0];
        end else begin
          cal_setting <= sum_dn[8] ? 8'h00 : sum_dn[7:0];
        end
        // [RULE3] adaptive halving on reversal
        if (cal_step_size == 4'h0 && reverse && delta_reg > 8'h01) begin
          delta_reg <= delta_reg >> 1;
        end
        last_up_reg <= cmp_low;
        iter_reg <= iter_reg + 8'h01;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  a_fixed_step_size: assert property (@(posedge ref_clk) disable iff (!rst_sync_b) // [RULE3]
    (state_reg == CAL_RUN && tick && !start && !settled && cmp_low && cal_step_size != 4'h0
     && cal_setting < 8'hF0)
    |=> cal_setting == $past(cal_setting) + {4'h0, $past(cal_step_size)})
    else $error("fixed step not applied");

  a_done_holds: assert property (@(posedge ref_clk) disable iff (!rst_sync_b) // [RULE4]
    (cal_done && !start) |=> cal_done)
    else $error("calibration done dropped without restart");
endmodule : cal_sequencer

// File: rtl/touch_setup_params.svh
// Offsets, field positions, reset values and timing counts of the touch setup registers.
// Assumes inclusion by bare name from the rtl directory.
`ifndef TOUCH_SETUP_PARAMS_SVH
`define TOUCH_SETUP_PARAMS_SVH

// Register offsets on the register port
`define OFS_SOFT_RESET 12'h001
`define OFS_IRQ_CONFIG 12'h008
`define OFS_TOUCH_CTRL 12'h040
`define OFS_IRQ_EN_LO 12'h043
`define OFS_IRQ_EN_HI 12'h044
`define OFS_FLAGS_LO 12'h045
`define OFS_FLAGS_HI 12'h046
`define OFS_CAL_CTRL 12'h04E
`define OFS_NOISE_CFG 12'h077

// Field positions
`define POS_TOUCH_EN 15
`define POS_IRQ_POL 15
`define POS_CAL_ACTIVE 14
`define POS_AMBIENT_CAL_DISABLE 13
`define POS_STEP_HI 3
`define POS_NOISE_ON 15
`define POS_NOISE_SET_HI 11
`define POS_CHAN_HI 9

// Reset values
`define RST_TOUCH_CTRL 16'h0000
`define RST_IRQ_CONFIG 16'h0000
`define RST_IRQ_EN_LO 16'h0000
`define RST_IRQ_EN_HI 16'h0300
`define RST_CAL_CTRL 16'h0002
`define RST_NOISE_CFG 16'h0000

// Calibration timing and limits
`define CLK_PERIOD_NS 10
`define CAL_TICK_NS 1000
`define CAL_TICK_CYCLES (`CAL_TICK_NS / `CLK_PERIOD_NS)
`define CAL_MAX_ITER 8'h20
`define CAL_SETTING_MID 8'h80
`define CAL_ADAPT_START 8'h08
`define NUM_CHANNELS 20
`define LAST_CHANNEL 5'h13

`endif

// File: rtl/touch_setup_pkg.sv
// Types shared by the touch setup register bank and its calibration sequencer.
// Assumes nothing of its surroundings.
package touch_setup_pkg;
  typedef enum logic [1:0] {
    CAL_IDLE = 2'h0,
    CAL_RUN = 2'h1,
    CAL_DONE = 2'h3
  } cal_state_t;
endpackage : touch_setup_pkg

// File: rtl/touch_setup_regs.sv
// Touch controller setup register bank: calibration, noise, enables, soft reset, interrupt.
// Assumes a decoded register port from the serial interface and front-end events on ref_clk.
//
// Function
// [RULE1] Calibration register bit 14 reads 0 while calibrating, 1 when done.
// [RULE2] Calibration bit 13 set suspends ambient baseline calibration; default active.
// [RULE3] Step field zero selects adaptive tracking, else fixed adjustment amount.
// [RULE4] Step parameter drives calibration of each channel to a no-touch baseline.
// [RULE5] Noise register holds enable bit 15 and settings 11:0, both reset zero.
// [RULE6] Touch sensing stays off until host sets touch control bit 15.
// [RULE7] Host enables every channel it wants reported before interrupt use.
// [RULE8] Interrupt enable bits 9:0 gate channels 0-9 and 10-19.
// [RULE9] Any write to soft reset register triggers a soft reset.
// [RULE10] Host soft-resets after configuring; device then runs initial calibration.
// [RULE11] Host reads both touch flag registers after an interrupt.
// [RULE12] Interrupt pin active low by default; polarity set by bit 15.
// [RULE13] Only enabled channels set flags and raise the interrupt.
`timescale 1ns/1ps
`include "touch_setup_params.svh"
module touch_setup_regs
  import touch_setup_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [11:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Front end
  input wire logic [19:0] touch_event,
  input wire logic cmp_high,
  input wire logic cmp_low,
  output logic sense_enable,
  output logic ambient_cal_en,
  output logic noise_rejection_on,
  output logic [11:0] noise_rejection_settings,
  output logic soft_reset_pulse,
  output logic [4:0] cal_chan,
  output logic [7:0] cal_setting,
  // Interrupt pin
  output logic irq_out_pin
);
  logic rst_meta_b;
  logic rst_sync_b;
  logic touch_en_reg;
  logic irq_polarity;
  logic [9:0] irq_en_lo_reg;
  logic [9:0] irq_en_hi_reg;
  logic ambient_cal_disable;
  logic [3:0] cal_step_size;
  logic [19:0] channel_touch_flags;
  logic [15:0] tick_cnt_reg;
  logic tick;
  logic cal_done;
  logic [19:0] irq_en_all;
  logic [19:0] flag_set;
  logic [19:0] flag_clr;
  logic irq_active;
  logic wr_soft;

  //////////////////////////////////////////////////////////////////////////////
  // Reset release
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      touch_en_reg <= 1'(`RST_TOUCH_CTRL >> `POS_TOUCH_EN);
      irq_polarity <= 1'(`RST_IRQ_CONFIG >> `POS_IRQ_POL);
      irq_en_lo_reg <= 10'(`RST_IRQ_EN_LO);
      irq_en_hi_reg <= 10'(`RST_IRQ_EN_HI);
      ambient_cal_disable <= 1'(`RST_CAL_CTRL >> `POS_AMBIENT_CAL_DISABLE);
      cal_step_size <= 4'(`RST_CAL_CTRL);
      noise_rejection_on <= 1'(`RST_NOISE_CFG >> `POS_NOISE_ON);
      noise_rejection_settings <= 12'(`RST_NOISE_CFG);
    end else if (reg_wr) begin
      case (reg_addr)
        // [RULE6] touch enable written by host
        `OFS_TOUCH_CTRL: touch_en_reg <= reg_wdata[`POS_TOUCH_EN];
        // [RULE12] polarity select
        `OFS_IRQ_CONFIG: irq_polarity <= reg_wdata[`POS_IRQ_POL];
        `OFS_IRQ_EN_LO: irq_en_lo_reg <= reg_wdata[`POS_CHAN_HI:0];
        `OFS_IRQ_EN_HI: irq_en_hi_reg <= reg_wdata[`POS_CHAN_HI:0];
        `OFS_CAL_CTRL: begin
          // [RULE2] ambient disable bit
          ambient_cal_disable <= reg_wdata[`POS_AMBIENT_CAL_DISABLE];
          cal_step_size <= reg_wdata[`POS_STEP_HI:0];
        end
        // [RULE5] noise enable and settings
        `OFS_NOISE_CFG: begin
          noise_rejection_on <= reg_wdata[`POS_NOISE_ON];
          noise_rejection_settings <= reg_wdata[`POS_NOISE_SET_HI:0];
        end
        default: begin
        end
      endcase
    end
  end

  // [RULE9] any write value triggers soft reset
  assign wr_soft = reg_wr && (reg_addr == `OFS_SOFT_RESET);

  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      soft_reset_pulse <= 1'b0;
    end else begin
      soft_reset_pulse <= wr_soft;
    end
  end

  // [RULE6] sensing only when host enabled it
  assign sense_enable = touch_en_reg;
  // [RULE2] ambient tracking after calibration unless suspended
  assign ambient_cal_en = cal_done && !ambient_cal_disable;

  //////////////////////////////////////////////////////////////////////////////
  // Calibration tick divider
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      tick_cnt_reg <= 16'h0000;
    end else if (tick) begin
      tick_cnt_reg <= 16'h0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
    end
  end
  assign tick = (tick_cnt_reg == 16'(`CAL_TICK_CYCLES - 1));

  // [RULE10] soft reset starts initial calibration
  cal_sequencer u_cal (
    .ref_clk(ref_clk),
    .rst_sync_b(rst_sync_b),
    .start(soft_reset_pulse),
    .tick(tick),
    .cal_step_size(cal_step_size),
    .cmp_high(cmp_high),
    .cmp_low(cmp_low),
    .cal_chan(cal_chan),
    .cal_setting(cal_setting),
    .cal_done(cal_done)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Touch flags: set wins over both read-clear and the soft reset clear
  assign irq_en_all = {irq_en_hi_reg, irq_en_lo_reg};

  genvar g;
  generate
    for (g = 0; g < `NUM_CHANNELS; g++) begin : g_flag
      // [RULE8] per-channel gate
      // [RULE13] only enabled channels flag
      assign flag_set[g] = touch_event[g] && irq_en_all[g] && touch_en_reg;
      assign flag_clr[g] = reg_rd && (reg_addr == ((g < 10) ? `OFS_FLAGS_LO : `OFS_FLAGS_HI));
      always_ff @(posedge ref_clk or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
          channel_touch_flags[g] <= 1'b0;
        end else if (flag_set[g]) begin
          channel_touch_flags[g] <= 1'b1;
        end else if (flag_clr[g] || soft_reset_pulse) begin
          channel_touch_flags[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign irq_active = |channel_touch_flags;

  // [RULE12] active level follows polarity
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      irq_out_pin <= 1'b1;
    end else begin
      irq_out_pin <= irq_active ? irq_polarity : !irq_polarity;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read data
  always_ff @(posedge ref_clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `OFS_TOUCH_CTRL: reg_rdata <= {touch_en_reg, 15'h0000};
        `OFS_IRQ_CONFIG: reg_rdata <= {irq_polarity, 15'h0000};
        `OFS_IRQ_EN_LO: reg_rdata <= {6'h00, irq_en_lo_reg};
        `OFS_IRQ_EN_HI: reg_rdata <= {6'h00, irq_en_hi_reg};
        `OFS_FLAGS_LO: reg_rdata <= {6'h00, channel_touch_flags[9:0]};
        `OFS_FLAGS_HI: reg_rdata <= {6'h00, channel_touch_flags[19:10]};
        // [RULE1] calibration status bit
        `OFS_CAL_CTRL: reg_rdata <= {1'b0, cal_done, ambient_cal_disable, 9'h000,
                                     4'h2 | cal_step_size};
        `OFS_NOISE_CFG: reg_rdata <= {noise_rejection_on, 3'h0, noise_rejection_settings};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  a_cal_status_read: assert property (@(posedge ref_clk) disable iff (!rst_sync_b) // [RULE1]
    (reg_rd && reg_addr == `OFS_CAL_CTRL) |=> reg_rdata[`POS_CAL_ACTIVE] == $past(cal_done))
    else $error("calibration status bit wrong");

  a_ambient_suspend: assert property (@(posedge ref_clk) disable iff (!rst_sync_b) // [RULE2]
    ambient_cal_disable |-> !ambient_cal_en)
    else $error("ambient calibration not suspended");

  a_noise_write: assert property (@(posedge ref_clk) disable iff (!rst_sync_b) // [RULE5]
    (reg_wr && reg_addr == `OFS_NOISE_CFG) |=>
    noise_rejection_on == $past(reg_wdata[15])
    && noise_rejection_settings == $past(reg_wdata[11:0]))
    else $error("noise register not stored");

  a_sense_gated: assert property (@(posedge ref_clk) disable iff (!rst_sync_b) // [RULE6]
    (reg_wr && reg_addr == `OFS_TOUCH_CTRL) |=> sense_enable == $past(reg_wdata[15]))
    else $error("touch enable not applied");

  a_disabled_no_flag: assert property (@(posedge ref_clk) disable iff (!rst_sync_b) // [RULE8]
    (touch_event[13] && !irq_en_all[13] && !channel_touch_flags[13]) |=> !channel_touch_flags[13])
    else $error("disabled channel set its flag");

  a_soft_reset_pulse: assert property (@(posedge ref_clk) disable iff (!rst_sync_b) // [RULE9]
    wr_soft |=> soft_reset_pulse ##1 !soft_reset_pulse || $past(wr_soft))
    else $error("soft reset not triggered");

  a_cal_restart: assert property (@(posedge ref_clk) disable iff (!rst_sync_b) // [RULE10]
    soft_reset_pulse |=> !cal_done && cal_chan == 5'h00)
    else $error("calibration not restarted by soft reset");

  a_irq_polarity: assert property (@(posedge ref_clk) disable iff (!rst_sync_b) // [RULE12]
    $past(irq_active) && $stable(irq_polarity) |-> irq_out_pin == irq_polarity)
    else $error("interrupt pin level wrong");

  a_flag_enabled: assert property (@(posedge ref_clk) disable iff (!rst_sync_b) // [RULE13]
    flag_set[12] |=> channel_touch_flags[12] ##1 !irq_out_pin == !irq_polarity)
    else $error("enabled touch did not raise interrupt");
endmodule : touch_setup_regs
